// >>> lic_line_ctrl.sv
// Line interface control and status registers on an AHB-Lite slave
//
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/1ns
`default_nettype none

module lic_line_ctrl
	import lic_pkg::*;
#(
	parameter int RING_HOLD = RING_HOLD_CYCLES,
	parameter int SLOT_BITS = SLOT_BITS_DEF
) (
	input wire logic MCLK,
	input wire logic RST,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	input wire logic RING_POSITIVE_IN,
	input wire logic RING_NEGATIVE_IN,
	input wire logic FRAME_SYNC_IN,
	input wire logic BIT_STROBE,
	input wire logic HIGHWAY_RECEIVE_PIN,
	input wire logic TX_FILTER_BIT,
	output logic RX_FILTER_BIT,
	output logic HIGHWAY_TRANSMIT_PIN,
	output logic SAMPLE_STROBE,
	output logic SAMPLE_SLOT,
	output logic LINE_SEIZE,
	output logic ONHOOK_MONITOR_ENABLE,
	output logic LINE_SIDE_POWERDOWN,
	output logic SYSTEM_SIDE_POWERDOWN,
	output logic WIDEBAND_SAMPLING_SELECT,
	output logic DIGITAL_LOOPBACK_ENABLE
);

	// ----------------------------------------------------------------
	// Parameter checks
	// ----------------------------------------------------------------
	localparam int TW = $clog2(RING_HOLD + 1);
	localparam int BW = $clog2(2 * SLOT_BITS + 1);
	generate
		if (RING_HOLD < 1) begin : g_bad_hold
			$error("RING_HOLD must be at least one cycle");
		end
		if (SLOT_BITS < 2) begin : g_bad_slot
			$error("SLOT_BITS must be at least two");
		end
	endgenerate

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	// Word index of a byte address, or 8'hFF when misaligned or out of map
	function automatic logic [7:0] reg_index(input logic [31:0] addr);
		logic [7:0] idx;
		idx = 8'hFF;
		if (addr[1:0] == 2'h0 && addr[31:10] == 22'h0) begin
			idx = addr[9:2];
		end
		return idx;
	endfunction : reg_index
	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [1:0] ring_sync;
	logic frame_sync;
	logic rx_sync;
	logic ring_pos_d_r;
	logic ring_neg_d_r;
	logic frame_d_r;
	logic pos_evt;
	logic neg_evt;
	logic ring_set;
	logic offhook_evt;
	logic fullwave_r;
	logic onhook_mon_r;
	logic ring_det_r;
	logic line_seize_r;
	logic line_pd_r;
	logic sys_pd_r;
	logic wideband_r;
	logic loopback_r;
	logic [TW-1:0] hold_r;
	logic [BW-1:0] bitcnt_r;
	logic [BW-1:0] bitcnt_nxt;
	logic wr_pend_r;
	logic [7:0] wr_idx_r;
	logic take;
	logic [7:0] rd_byte;
	logic [7:0] wdat;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	// Ring pins, frame sync and highway data all come from outside
	lic_sync2 #(.W(4)) u_sync (
		.clk(MCLK),
		.rst(RST),
		.din({RING_NEGATIVE_IN, RING_POSITIVE_IN, FRAME_SYNC_IN,
			HIGHWAY_RECEIVE_PIN}),
		.dout({ring_sync, frame_sync, rx_sync})
	);

	// Previous synchronised levels for edge detection
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			ring_pos_d_r <= 1'b0;
			ring_neg_d_r <= 1'b0;
			frame_d_r <= 1'b0;
		end else begin
			ring_pos_d_r <= ring_sync[0];
			ring_neg_d_r <= ring_sync[1];
			frame_d_r <= frame_sync;
		end
	end

	assign pos_evt = ring_sync[0] & ~ring_pos_d_r;
	assign neg_evt = ring_sync[1] & ~ring_neg_d_r;
	// ----------------------------------------------------------------
	// AHB-Lite slave
	// ----------------------------------------------------------------
	// Address phase accepted when selected, active and bus ready
	assign take = HSEL & HREADY & (HTRANS == HTRANS_NONSEQ |
		HTRANS == HTRANS_SEQ);

	// Zero-wait slave, always OKAY
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			HREADYOUT <= 1'b1;
			HRESP <= 1'b0;
		end else begin
			HREADYOUT <= 1'b1;
			HRESP <= 1'b0;
		end
	end

	// Write address captured for the following data phase
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			wr_pend_r <= 1'b0;
			wr_idx_r <= 8'hFF;
		end else begin
			wr_pend_r <= take & HWRITE & (HSIZE == HSIZE_WORD);
			wr_idx_r <= reg_index(HADDR);
		end
	end
	// Write data byte, valid in the data phase
	assign wdat = HWDATA[7:0];

	// Read mux; unused bits and unmapped words read zero
	always_comb begin
		rd_byte = 8'h00;
		case (reg_index(HADDR))
			IDX_RING_CONFIG: rd_byte[BIT_FULLWAVE] = fullwave_r;
			IDX_LINE_CTRL_ONE: begin
				rd_byte[BIT_RING_NEG] = ring_sync[1];
				rd_byte[BIT_RING_POS] = ring_sync[0];
				rd_byte[BIT_ONHOOK_MON] = onhook_mon_r;
				rd_byte[BIT_RING_DET] = ring_det_r;
				rd_byte[BIT_LINE_SEIZE] = line_seize_r;
			end
			IDX_POWER_CTRL: begin
				rd_byte[BIT_LINE_PD] = line_pd_r;
				rd_byte[BIT_SYS_PD] = sys_pd_r;
			end
			IDX_SAMPLE_RATE: rd_byte[BIT_WIDEBAND] = wideband_r;
			IDX_LOOPBACK: rd_byte[BIT_LOOPBACK] = loopback_r;
			default: rd_byte = 8'h00;
		endcase
	end

	// Read data registered in the address phase, held otherwise
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			HRDATA <= 32'h00000000;
		end else if (take & ~HWRITE) begin
			HRDATA <= {24'h000000, rd_byte};
		end
	end

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------
	// Full-wave ring select
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			fullwave_r <= RST_RING_CONFIG[BIT_FULLWAVE];
		end else if (wr_pend_r && wr_idx_r == IDX_RING_CONFIG) begin
			fullwave_r <= wdat[BIT_FULLWAVE];
		end
	end

	// Line seize and on-hook monitor; other bits are read-only
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			line_seize_r <= RST_LINE_CTRL_ONE[BIT_LINE_SEIZE];
			onhook_mon_r <= RST_LINE_CTRL_ONE[BIT_ONHOOK_MON];
		end else if (wr_pend_r && wr_idx_r == IDX_LINE_CTRL_ONE) begin
			line_seize_r <= wdat[BIT_LINE_SEIZE];
			onhook_mon_r <= wdat[BIT_ONHOOK_MON];
		end
	end

	// Line-side powerdown starts set; clock setup is software's job
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			line_pd_r <= RST_POWER_CTRL[BIT_LINE_PD];
		end else if (wr_pend_r && wr_idx_r == IDX_POWER_CTRL) begin
			line_pd_r <= wdat[BIT_LINE_PD];
		end
	end

	// System powerdown is sticky; only the reset pin releases it
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			sys_pd_r <= RST_POWER_CTRL[BIT_SYS_PD];
		end else if (wr_pend_r && wr_idx_r == IDX_POWER_CTRL &&
			wdat[BIT_SYS_PD]) begin
			sys_pd_r <= 1'b1;
		end
	end

	// Sample rate select
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			wideband_r <= RST_SAMPLE_RATE[BIT_WIDEBAND];
		end else if (wr_pend_r && wr_idx_r == IDX_SAMPLE_RATE) begin
			wideband_r <= wdat[BIT_WIDEBAND];
		end
	end

	// Digital loopback enable
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			loopback_r <= RST_LOOPBACK[BIT_LOOPBACK];
		end else if (wr_pend_r && wr_idx_r == IDX_LOOPBACK) begin
			loopback_r <= wdat[BIT_LOOPBACK];
		end
	end

	// ----------------------------------------------------------------
	// Ring detect flag and hold timer
	// ----------------------------------------------------------------
	// Negative rings count only in full-wave mode
	assign ring_set = pos_evt | (fullwave_r & neg_evt);

	// Off-hook taken as the write that raises the seize bit
	assign offhook_evt = wr_pend_r && wr_idx_r == IDX_LINE_CTRL_ONE &&
		wdat[BIT_LINE_SEIZE] && !line_seize_r;

	// Timer reloads on each ring; a new ring beats any clear
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			ring_det_r <= RST_LINE_CTRL_ONE[BIT_RING_DET];
			hold_r <= '0;
		end else if (ring_set) begin
			ring_det_r <= 1'b1;
			hold_r <= TW'(RING_HOLD);
		end else if (offhook_evt) begin
			ring_det_r <= 1'b0;
			hold_r <= '0;
		end else if (hold_r != '0) begin
			hold_r <= hold_r - TW'(1);
			if (hold_r == TW'(1)) begin
				ring_det_r <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Sample timing on the 8 kHz highway frame
	// ----------------------------------------------------------------
	// Bit position within the frame, saturating past two slots
	always_comb begin
		bitcnt_nxt = bitcnt_r;
		if (frame_sync & ~frame_d_r) begin
			bitcnt_nxt = '0;
		end else if (BIT_STROBE && bitcnt_r != BW'(2 * SLOT_BITS)) begin
			bitcnt_nxt = bitcnt_r + BW'(1);
		end
	end
	// Bit counter, parked at its end until a frame starts
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			bitcnt_r <= BW'(2 * SLOT_BITS);
		end else begin
			bitcnt_r <= bitcnt_nxt;
		end
	end

	// One sample per frame, or a second one in the adjacent slot
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			SAMPLE_STROBE <= 1'b0;
			SAMPLE_SLOT <= 1'b0;
		end else if (frame_sync & ~frame_d_r) begin
			SAMPLE_STROBE <= 1'b1;
			SAMPLE_SLOT <= 1'b0;
		end else if (wideband_r && BIT_STROBE &&
			bitcnt_r == BW'(SLOT_BITS - 1)) begin
			SAMPLE_STROBE <= 1'b1;
			SAMPLE_SLOT <= 1'b1;
		end else begin
			SAMPLE_STROBE <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Highway data path
	// ----------------------------------------------------------------
	// Received bit goes to the receive filter; loopback bypasses filters
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			RX_FILTER_BIT <= 1'b0;
			HIGHWAY_TRANSMIT_PIN <= 1'b0;
		end else begin
			RX_FILTER_BIT <= rx_sync;
			if (loopback_r) begin
				HIGHWAY_TRANSMIT_PIN <= rx_sync;
			end else begin
				HIGHWAY_TRANSMIT_PIN <= TX_FILTER_BIT;
			end
		end
	end

	// ----------------------------------------------------------------
	// Control outputs to the line side and system
	// ----------------------------------------------------------------
	// Registered copies, monitor enable masked by line seize, so each control pin comes from a flop
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			LINE_SEIZE <= 1'b0;
			ONHOOK_MONITOR_ENABLE <= 1'b0;
			LINE_SIDE_POWERDOWN <= 1'b1;
			SYSTEM_SIDE_POWERDOWN <= 1'b0;
			WIDEBAND_SAMPLING_SELECT <= 1'b0;
			DIGITAL_LOOPBACK_ENABLE <= 1'b0;
		end else begin
			LINE_SEIZE <= line_seize_r;
			ONHOOK_MONITOR_ENABLE <= onhook_mon_r & ~line_seize_r;
			LINE_SIDE_POWERDOWN <= line_pd_r;
			SYSTEM_SIDE_POWERDOWN <= sys_pd_r;
			WIDEBAND_SAMPLING_SELECT <= wideband_r;
			DIGITAL_LOOPBACK_ENABLE <= loopback_r;
		end
	end

endmodule : lic_line_ctrl
`default_nettype wire

// >>> lic_pkg.sv
// Constants shared by the line interface control register block
package lic_pkg;

	// ----------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_RING_CONFIG = 8'h02;
	localparam logic [7:0] IDX_LINE_CTRL_ONE = 8'h05;
	localparam logic [7:0] IDX_POWER_CTRL = 8'h06;
	localparam logic [7:0] IDX_SAMPLE_RATE = 8'h07;
	localparam logic [7:0] IDX_RESERVED_A = 8'h08;
	localparam logic [7:0] IDX_RESERVED_B = 8'h09;
	localparam logic [7:0] IDX_LOOPBACK = 8'h0A;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int BIT_FULLWAVE = 0;
	localparam int BIT_RING_NEG = 6;
	localparam int BIT_RING_POS = 5;
	localparam int BIT_ONHOOK_MON = 3;
	localparam int BIT_RING_DET = 2;
	localparam int BIT_LINE_SEIZE = 0;
	localparam int BIT_LINE_PD = 4;
	localparam int BIT_SYS_PD = 3;
	localparam int BIT_WIDEBAND = 3;
	localparam int BIT_LOOPBACK = 0;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_RING_CONFIG = 8'h00;
	localparam logic [7:0] RST_LINE_CTRL_ONE = 8'h00;
	localparam logic [7:0] RST_POWER_CTRL = 8'h10;
	localparam logic [7:0] RST_SAMPLE_RATE = 8'h00;
	localparam logic [7:0] RST_LOOPBACK = 8'h00;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 100_000_000;
	localparam int RING_HOLD_S = 5;
	localparam int RING_HOLD_CYCLES = RING_HOLD_S * CLK_HZ;
	localparam int SLOT_BITS_DEF = 8;

	// ----------------------------------------------------------------
	// AHB-Lite encodings
	// ----------------------------------------------------------------
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ = 2'h3;
	localparam logic [2:0] HSIZE_WORD = 3'h2;

endpackage : lic_pkg

// >>> lic_sync2.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none

module lic_sync2 #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);

	logic [W-1:0] meta_r;

	// First stage feeds only the second stage
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_r <= '0;
			dout <= '0;
		end else begin
			meta_r <= din;
			dout <= meta_r;
		end
	end

endmodule : lic_sync2

`default_nettype wire

// >>> lic_line_ctrl_assertions.sv
// Concurrent checks on the line interface control block ports
`timescale 1ns/1ns
`default_nettype none
// ----
// Checker
// ----
module lic_chk
	import lic_pkg::*;
(
	input wire logic MCLK,
	input wire logic RST,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	input wire logic [31:0] HRDATA,
	input wire logic HREADYOUT,
	input wire logic HRESP,
	input wire logic FRAME_SYNC_IN,
	input wire logic TX_FILTER_BIT,
	input wire logic RX_FILTER_BIT,
	input wire logic HIGHWAY_TRANSMIT_PIN,
	input wire logic SAMPLE_STROBE,
	input wire logic SAMPLE_SLOT,
	input wire logic LINE_SEIZE,
	input wire logic ONHOOK_MONITOR_ENABLE,
	input wire logic LINE_SIDE_POWERDOWN,
	input wire logic SYSTEM_SIDE_POWERDOWN,
	input wire logic WIDEBAND_SAMPLING_SELECT,
	input wire logic DIGITAL_LOOPBACK_ENABLE
);
	default clocking dc @(posedge MCLK);
	endclocking
	default disable iff (RST);
	// Word write taken in its address phase
	sequence wr_take(a);
		HSEL && HREADY && HTRANS == HTRANS_NONSEQ && HWRITE &&
			HSIZE == HSIZE_WORD && HADDR == a;
	endsequence
	// Written bit shows on its output two edges after the data phase
	property wr_bit_p(a, b, o);
		wr_take(a) ##1 1'b1 |-> ##2 o == $past(HWDATA[b], 2);
	endproperty
	bus_okay_a: assert property (
		HREADYOUT && !HRESP && HRDATA[31:8] == 24'h0)
		else $error("bus answer not zero-wait okay");
	seize_out_a: assert property (
		wr_bit_p(32'h14, BIT_LINE_SEIZE, LINE_SEIZE))
		else $error("seize output does not follow write");
	line_pd_a: assert property (
		wr_bit_p(32'h18, BIT_LINE_PD, LINE_SIDE_POWERDOWN))
		else $error("line powerdown does not follow write");
	rate_out_a: assert property (
		wr_bit_p(32'h1C, BIT_WIDEBAND, WIDEBAND_SAMPLING_SELECT))
		else $error("rate select does not follow write");
	loop_out_a: assert property (
		wr_bit_p(32'h28, BIT_LOOPBACK, DIGITAL_LOOPBACK_ENABLE))
		else $error("loopback enable does not follow write");
	sys_pd_hold_a: assert property (
		SYSTEM_SIDE_POWERDOWN |=> SYSTEM_SIDE_POWERDOWN)
		else $error("system powerdown left without reset");
	reset_out_a: assert property (
		$fell(RST) |-> LINE_SIDE_POWERDOWN && !SYSTEM_SIDE_POWERDOWN)
		else $error("wrong powerdown state after reset");
	mon_off_a: assert property (ONHOOK_MONITOR_ENABLE |-> !LINE_SEIZE)
		else $error("monitor active while off-hook");
	loop_data_a: assert property (
		DIGITAL_LOOPBACK_ENABLE && $past(DIGITAL_LOOPBACK_ENABLE) &&
		!$past(RST) |-> HIGHWAY_TRANSMIT_PIN == RX_FILTER_BIT)
		else $error("looped data differs from received data");
	tx_path_a: assert property (
		!DIGITAL_LOOPBACK_ENABLE && !$past(DIGITAL_LOOPBACK_ENABLE) &&
		!$past(RST) |-> HIGHWAY_TRANSMIT_PIN == $past(TX_FILTER_BIT))
		else $error("transmit pin not fed by filter");
	frame_slot_a: assert property (
		$rose(FRAME_SYNC_IN) |-> ##[2:4] SAMPLE_STROBE && !SAMPLE_SLOT)
		else $error("no first-slot sample after frame start");
	strobe_pulse_a: assert property (SAMPLE_STROBE |=> !SAMPLE_STROBE)
		else $error("sample strobe longer than one cycle");
endmodule : lic_chk
bind lic_line_ctrl lic_chk i_chk (
	.MCLK, .RST, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE, .HWDATA, .HREADY,
	.HRDATA, .HREADYOUT, .HRESP, .FRAME_SYNC_IN, .TX_FILTER_BIT,
	.RX_FILTER_BIT, .HIGHWAY_TRANSMIT_PIN, .SAMPLE_STROBE, .SAMPLE_SLOT,
	.LINE_SEIZE, .ONHOOK_MONITOR_ENABLE, .LINE_SIDE_POWERDOWN,
	.SYSTEM_SIDE_POWERDOWN, .WIDEBAND_SAMPLING_SELECT,
	.DIGITAL_LOOPBACK_ENABLE
);
`default_nettype wire

// >>> lic_far.sv
// Highway side model: frame sync, bit strobes and serial data
`timescale 1ns/1ns
`default_nettype none
// ----
// Far side model
// ----
module lic_far (
	input wire logic mclk,
	input wire logic rst,
	output logic frame_sync,
	output logic bit_strobe,
	output logic rx_pin,
	output logic tx_bit
);
	logic [5:0] cnt_r;
	// Frame position, 64 cycles a frame, restarted by reset
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			cnt_r <= 6'h00;
		else
			cnt_r <= cnt_r + 6'h01;
	end
	// Sixteen bit periods a frame, sync high for one of them
	assign frame_sync = cnt_r[5:2] == 4'h2;
	assign bit_strobe = cnt_r[1:0] == 2'h3;
	// Data changes often so a stale or shifted copy never matches
	assign rx_pin = cnt_r[0] ^ cnt_r[2] ^ cnt_r[5];
	assign tx_bit = cnt_r[1] ^ cnt_r[3];
endmodule : lic_far
`default_nettype wire

// >>> test_line_interface_control_regs.sv
// Self-checking bench for the line interface control registers
`timescale 1ns/1ns
`default_nettype none
// ----
// Bench top
// ----
module test_line_interface_control_regs
	import lic_pkg::*;
;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic ring_p = 1'b0;
	logic ring_n = 1'b0;
	logic [31:0] hrdata, rd;
	logic rdy, resp, fs, bs, rxp, txf, rxf, txp, sstb, sslot;
	logic seize, mon, lpd, spd, wide, lbe;
	int bad_count = 0;
	int tests_run = 0;
	// Clock of 10 ns
	always #5 mclk = ~mclk;
	lic_far i_far (.mclk(mclk), .rst(rst), .frame_sync(fs),
		.bit_strobe(bs), .rx_pin(rxp), .tx_bit(txf));
	lic_line_ctrl #(.RING_HOLD(50)) i_dut (
		.MCLK(mclk), .RST(rst), .HSEL(hsel), .HADDR(haddr),
		.HTRANS(htrans), .HWRITE(hwrite), .HSIZE(HSIZE_WORD),
		.HWDATA(hwdata), .HREADY(rdy), .HRDATA(hrdata),
		.HREADYOUT(rdy), .HRESP(resp), .RING_POSITIVE_IN(ring_p),
		.RING_NEGATIVE_IN(ring_n), .FRAME_SYNC_IN(fs),
		.BIT_STROBE(bs), .HIGHWAY_RECEIVE_PIN(rxp),
		.TX_FILTER_BIT(txf), .RX_FILTER_BIT(rxf),
		.HIGHWAY_TRANSMIT_PIN(txp), .SAMPLE_STROBE(sstb),
		.SAMPLE_SLOT(sslot), .LINE_SEIZE(seize),
		.ONHOOK_MONITOR_ENABLE(mon), .LINE_SIDE_POWERDOWN(lpd),
		.SYSTEM_SIDE_POWERDOWN(spd), .WIDEBAND_SAMPLING_SELECT(wide),
		.DIGITAL_LOOPBACK_ENABLE(lbe));
	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			$display("Error at %0t: got %h expected %h", $time, got, exp);
			bad_count++;
		end
	endtask : chk
	// One single transfer; read data lands in rd
	task automatic bus(input logic [31:0] a, input logic w,
		input logic [31:0] d);
		@(posedge mclk);
		hsel <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		haddr <= a;
		hwrite <= w;
		do @(posedge mclk); while (rdy !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge mclk); while (rdy !== 1'b1);
		rd = hrdata;
	endtask : bus
	task automatic rchk(input logic [31:0] a, input logic [31:0] e);
		bus(a, 1'b0, 32'h0);
		chk(rd, e);
	endtask : rchk
	task automatic pulse_reset;
		rst <= 1'b1;
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
	endtask : pulse_reset
	task automatic t_reset;
		rchk(32'h14, 32'h00);
		rchk(32'h18, 32'h10);
		rchk(32'h1C, 32'h00);
		rchk(32'h20, 32'h00);
		rchk(32'h28, 32'h00);
		rchk(32'h3FC, 32'h00);
		chk(lpd, 1'b1);
		$display("reset values done");
	endtask : t_reset
	task automatic t_hook;
		bus(32'h24, 1'b1, 32'hFF);
		rchk(32'h24, 32'h00);
		bus(32'h14, 1'b1, 32'hFF);
		rchk(32'h14, 32'h09);
		repeat (2) @(posedge mclk);
		chk({mon, seize}, 2'h1);
		bus(32'h14, 1'b1, 32'h08);
		repeat (2) @(posedge mclk);
		chk({mon, seize}, 2'h2);
		$display("hook control done");
	endtask : t_hook
	task automatic t_power;
		bus(32'h1C, 1'b1, 32'h00);
		bus(32'h18, 1'b1, 32'h00);
		repeat (2) @(posedge mclk);
		chk(lpd, 1'b0);
		bus(32'h18, 1'b1, 32'h08);
		bus(32'h18, 1'b1, 32'h00);
		rchk(32'h18, 32'h08);
		chk(spd, 1'b1);
		pulse_reset;
		chk(spd, 1'b0);
		rchk(32'h18, 32'h10);
		$display("powerdown done");
	endtask : t_power
	task automatic t_rate(input logic w);
		int n;
		int s;
		bus(32'h1C, 1'b1, {28'h0, w, 3'h0});
		rchk(32'h1C, {28'h0, w, 3'h0});
		repeat (67) @(posedge mclk);
		chk(wide, w);
		n = 0;
		s = 0;
		repeat (64) begin
			@(posedge mclk);
			if (sstb === 1'b1)
				n++;
			if (sstb === 1'b1 && sslot === 1'b1)
				s++;
		end
		chk(n, w ? 2 : 1);
		chk(s, w);
		$display("sample rate done");
	endtask : t_rate
	task automatic t_loop;
		logic [2:0] h;
		logic t;
		bus(32'h28, 1'b1, 32'h01);
		rchk(32'h28, 32'h01);
		repeat (4) @(posedge mclk);
		h = 3'h0;
		for (int i = 0; i < 24; i++) begin
			@(posedge mclk);
			if (i > 2) begin
				chk(txp, h[2]);
				chk(rxf, h[2]);
			end
			h = {h[1:0], rxp};
		end
		bus(32'h28, 1'b1, 32'h00);
		repeat (4) @(posedge mclk);
		t = txf;
		repeat (8) begin
			@(posedge mclk);
			chk(txp, t);
			t = txf;
		end
		$display("loopback done");
	endtask : t_loop
	task automatic t_ring;
		ring_p <= 1'b1;
		repeat (6) @(posedge mclk);
		rchk(32'h14, 32'h24);
		ring_p <= 1'b0;
		repeat (3) @(posedge mclk);
		rchk(32'h14, 32'h04);
		repeat (60) @(posedge mclk);
		rchk(32'h14, 32'h00);
		ring_n <= 1'b1;
		repeat (6) @(posedge mclk);
		rchk(32'h14, 32'h40);
		ring_n <= 1'b0;
		bus(32'h08, 1'b1, 32'h01);
		ring_n <= 1'b1;
		repeat (6) @(posedge mclk);
		rchk(32'h14, 32'h44);
		bus(32'h14, 1'b1, 32'h01);
		rchk(32'h14, 32'h41);
		ring_n <= 1'b0;
		$display("ring detect done");
	endtask : t_ring
	task automatic complete_run;
		$display("checks %0d, mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : complete_run
	// Main sequence
	initial begin
		pulse_reset;
		t_reset;
		t_hook;
		t_power;
		t_rate(1'b1);
		t_rate(1'b0);
		t_loop;
		t_ring;
		complete_run;
	end
	// Watchdog against a hung bus
	initial begin
		repeat (5000) @(posedge mclk);
		bad_count++;
		complete_run;
	end
endmodule : test_line_interface_control_regs
`default_nettype wire
